//--- rtl/pll_clk_defs.svh
// What this block does
// - VCO equals N times reference clock.
// - Multiplier zero behaves exactly like one.
// - L zero disables PLL, forces crystal.
// - Source change waits, output held static.
// - Selected clock divided by two.
// - Select bit chooses crystal or VCO.
// - VCO not selectable while PLL off.
// - PLL not switchable off while VCO selected.
// - One write cannot change both bits.
// - Integration enable gates oscillator and PLL.
// - Select bit held clear when PLL on bit clear or L zero.
// - Programming registers read-only while PLL on.
`ifndef PLL_CLK_DEFS_SVH
`define PLL_CLK_DEFS_SVH
`define IDX_CTL        6'h36
`define IDX_MUL_HI     6'h38
`define IDX_MUL_LO     6'h39
`define IDX_RANGE      6'h3a
`define IDX_STATUS     6'h3c
`define CTL_ON_BIT     5
`define CTL_SEL_BIT    4
`define CTL_VPR_LSB    0
`define CTL_RST        8'h20
`define MUL_HI_RST     4'h0
`define MUL_LO_RST     8'h40
`define RANGE_RST      8'h40
`define SETTLE_EDGES   3
`define RESP_OKAY      2'h0
`define RESP_SLVERR    2'h2
`endif

//--- rtl/pll_clk_pkg.sv
package pll_clk_pkg;
   typedef enum logic [1:0] {
      SW_RUN,
      SW_STOP_OLD,
      SW_START_NEW
   } sw_state_t;
   typedef logic [5:0] reg_idx_t;
endpackage

//--- rtl/clk_source_switch.sv
`timescale 1ns/100ps
`default_nettype none
`include "pll_clk_defs.svh"
module clk_source_switch #(
   parameter int SETTLE = `SETTLE_EDGES
) (
   input  wire logic core_clk_i,
   input  wire logic srst_i,
   input  wire logic ce_i,
   input  wire logic crystal_clock_i,
   input  wire logic vco_clock_i,
   input  wire logic sel_vco_i,
   output logic      base_clock_out_o,
   output logic      active_vco_o,
   output logic      busy_o
);
   import pll_clk_pkg::*;
   generate
      if (SETTLE < 1 || SETTLE > 15) begin : g_bad
         $error("SETTLE must be 1 to 15");
      end
   endgenerate
   logic [1:0] x_sync_q, v_sync_q;
   logic       x_last_q, v_last_q;
   logic       out_q, act_q;
   logic [3:0] cnt_q;
   sw_state_t  st_q;
   wire        x_rise = x_sync_q[1] & ~x_last_q;
   wire        v_rise = v_sync_q[1] & ~v_last_q;
   wire        old_rise = act_q ? v_rise : x_rise;
   wire        old_lvl = act_q ? v_sync_q[1] : x_sync_q[1];
   wire        new_rise = sel_vco_i ? v_rise : x_rise;
   // ----------------------------------------
   // Synchronisers and transition control
   // ----------------------------------------
   always_ff @(posedge core_clk_i) begin
      if (srst_i) begin
         x_sync_q <= 2'h0;
         v_sync_q <= 2'h0;
         x_last_q <= 1'b0;
         v_last_q <= 1'b0;
      end else if (ce_i) begin
         x_sync_q <= {x_sync_q[0], crystal_clock_i};
         v_sync_q <= {v_sync_q[0], vco_clock_i};
         x_last_q <= x_sync_q[1];
         v_last_q <= v_sync_q[1];
      end
   end
   // The old source is dropped only in its low phase, so no runt pulse escapes.
   always_ff @(posedge core_clk_i) begin
      if (srst_i) begin
         st_q  <= SW_RUN;
         out_q <= 1'b0;
         act_q <= 1'b0;
         cnt_q <= 4'h0;
      end else if (ce_i) begin
         unique case (st_q)
            SW_RUN: begin
               if (sel_vco_i != act_q) begin
                  st_q <= SW_STOP_OLD;
               end else if (old_rise) begin
                  out_q <= ~out_q;
               end
            end
            SW_STOP_OLD: begin
               if (!old_lvl) begin
                  act_q <= sel_vco_i;
                  cnt_q <= 4'h0;
                  st_q  <= SW_START_NEW;
               end
            end
            SW_START_NEW: begin
               if (sel_vco_i != act_q) begin
                  st_q <= SW_STOP_OLD;
               end else if (new_rise) begin
                  cnt_q <= cnt_q + 4'h1;
                  if (cnt_q == 4'(SETTLE - 1)) begin
                     st_q <= SW_RUN;
                  end
               end
            end
         endcase
      end
   end
   assign base_clock_out_o = out_q;
   assign active_vco_o     = act_q;
   assign busy_o           = (st_q != SW_RUN);
   chk_static_hold: assert property (@(posedge core_clk_i) disable iff (srst_i)
      (st_q != SW_RUN) |=> (out_q == $past(out_q)))
      else $error("base clock moved during transition");
   chk_div_edge: assert property (@(posedge core_clk_i) disable iff (srst_i)
      (out_q != $past(out_q)) |-> $past(old_rise && ce_i && st_q == SW_RUN))
      else $error("base clock toggled without source edge");
   chk_switch_low: assert property (@(posedge core_clk_i) disable iff (srst_i)
      (act_q != $past(act_q)) |-> $past(!old_lvl && st_q == SW_STOP_OLD))
      else $error("source dropped while high");
endmodule // clk_source_switch
`default_nettype wire

//--- rtl/pll_base_clock_select.sv
// Added by the designer: the AXI4-Lite register port and the placing of the registers.
`timescale 1ns/100ps
`default_nettype none
`include "pll_clk_defs.svh"
module pll_base_clock_select #(
   parameter int MUL_W    = 12,
   parameter int SETTLE   = `SETTLE_EDGES
) (
   input  wire logic                 core_clk_i,
   input  wire logic                 srst_i,
   input  wire logic                 ce_i,
   input  wire logic                 osc_enable_from_sysint_i,
   input  wire logic                 crystal_clock_i,
   input  wire logic                 vco_clock_i,
   input  wire logic [7:0]           s_axi_awaddr_i,
   input  wire logic                 s_axi_awvalid_i,
   output logic                      s_axi_awready_o,
   input  wire logic [31:0]          s_axi_wdata_i,
   input  wire logic [3:0]           s_axi_wstrb_i,
   input  wire logic                 s_axi_wvalid_i,
   output logic                      s_axi_wready_o,
   output logic [1:0]                s_axi_bresp_o,
   output logic                      s_axi_bvalid_o,
   input  wire logic                 s_axi_bready_i,
   input  wire logic [7:0]           s_axi_araddr_i,
   input  wire logic                 s_axi_arvalid_i,
   output logic                      s_axi_arready_o,
   output logic [31:0]               s_axi_rdata_o,
   output logic [1:0]                s_axi_rresp_o,
   output logic                      s_axi_rvalid_o,
   input  wire logic                 s_axi_rready_i,
   output logic                      base_clock_out_o,
   output logic                      osc_enable_o,
   output logic                      pll_enable_o,
   output logic [MUL_W-1:0]          multiplier_o,
   output logic [7:0]                vco_range_o,
   output logic [1:0]                vco_power_range_bits_o,
   output logic                      switch_busy_o,
   output logic                      active_vco_o
);
   import pll_clk_pkg::*;
   localparam logic [7:0] CTL_RESET = `CTL_RST;
   generate
      if (MUL_W != 12) begin : g_bad_w
         $error("MUL_W must be 12 to fit the high and low registers");
      end
   endgenerate

   // ----------------------------------------
   // Helper functions
   // ----------------------------------------
   function automatic reg_idx_t reg_index(input logic [7:0] a);
      return a[7:2];
   endfunction

   function automatic logic mapped(input reg_idx_t i);
      return (i == `IDX_CTL) || (i == `IDX_MUL_HI) || (i == `IDX_MUL_LO) ||
             (i == `IDX_RANGE) || (i == `IDX_STATUS);
   endfunction

   // ----------------------------------------
   // Register state
   // ----------------------------------------
   logic              pll_on_bit_q, pll_on_bit_d;
   logic              base_clock_select_bit_q, base_clock_select_bit_d;
   logic [1:0]        vpr_q;
   logic [3:0]        mul_hi_q;
   logic [7:0]        mul_lo_q;
   logic [7:0]        range_q;
   logic              pll_en_q;
   logic [MUL_W-1:0]  mul_eff_q;

   // ----------------------------------------
   // Write channel
   // ----------------------------------------
   logic              aw_full_q, w_full_q, bvalid_q;
   logic [7:0]        aw_addr_q;
   logic [31:0]       w_data_q;
   logic              w_strb0_q;
   logic [1:0]        bresp_q;

   wire aw_take = s_axi_awvalid_i & s_axi_awready_o;
   wire w_take  = s_axi_wvalid_i & s_axi_wready_o;
   wire wr_fire = ce_i & aw_full_q & w_full_q & ~bvalid_q;
   wire reg_idx_t widx = reg_index(aw_addr_q);
   wire wr_ok   = wr_fire & w_strb0_q;
   wire ctl_wr  = wr_ok & (widx == `IDX_CTL);
   wire hi_wr   = wr_ok & (widx == `IDX_MUL_HI);
   wire lo_wr   = wr_ok & (widx == `IDX_MUL_LO);
   wire rng_wr  = wr_ok & (widx == `IDX_RANGE);
   wire prog_ok = ~pll_on_bit_q;
   wire wr_on   = w_data_q[`CTL_ON_BIT];
   wire wr_sel  = w_data_q[`CTL_SEL_BIT];
   wire l_zero  = (range_q == 8'h00);

   assign s_axi_awready_o = ce_i & ~aw_full_q & ~bvalid_q;
   assign s_axi_wready_o  = ce_i & ~w_full_q & ~bvalid_q;
   assign s_axi_bvalid_o  = bvalid_q;
   assign s_axi_bresp_o   = bresp_q;

   always_ff @(posedge core_clk_i) begin
      if (srst_i) begin
         aw_full_q <= 1'b0;
         w_full_q  <= 1'b0;
         bvalid_q  <= 1'b0;
         aw_addr_q <= 8'h00;
         w_data_q  <= 32'h0000_0000;
         w_strb0_q <= 1'b0;
         bresp_q   <= `RESP_OKAY;
      end else if (ce_i) begin
         if (aw_take) begin
            aw_full_q <= 1'b1;
            aw_addr_q <= s_axi_awaddr_i;
         end
         if (w_take) begin
            w_full_q  <= 1'b1;
            w_data_q  <= s_axi_wdata_i;
            w_strb0_q <= s_axi_wstrb_i[0];
         end
         if (wr_fire) begin
            aw_full_q <= 1'b0;
            w_full_q  <= 1'b0;
            bvalid_q  <= 1'b1;
            bresp_q   <= mapped(widx) ? `RESP_OKAY : `RESP_SLVERR;
         end else if (bvalid_q && s_axi_bready_i) begin
            bvalid_q  <= 1'b0;
         end
      end
   end

   // ----------------------------------------
   // Control interlocks
   // ----------------------------------------
   // Both interlocks weigh the on bit being written against the present bits, not against the bits after the write.
   always_comb begin
      pll_on_bit_d = pll_on_bit_q;
      if (ctl_wr) begin
         if (base_clock_select_bit_q && !wr_on) begin
            pll_on_bit_d = 1'b1;
         end else begin
            pll_on_bit_d = wr_on;
         end
      end
   end

   always_comb begin
      base_clock_select_bit_d = base_clock_select_bit_q;
      if (!pll_on_bit_q || l_zero) begin
         base_clock_select_bit_d = 1'b0;
      end else if (ctl_wr && (wr_on == pll_on_bit_q)) begin
         base_clock_select_bit_d = wr_sel;
      end
   end

   always_ff @(posedge core_clk_i) begin
      if (srst_i) begin
         pll_on_bit_q            <= CTL_RESET[`CTL_ON_BIT];
         base_clock_select_bit_q <= 1'b0;
         vpr_q                   <= 2'h0;
         mul_hi_q                <= `MUL_HI_RST;
         mul_lo_q                <= `MUL_LO_RST;
         range_q                 <= `RANGE_RST;
      end else if (ce_i) begin
         pll_on_bit_q            <= pll_on_bit_d;
         base_clock_select_bit_q <= base_clock_select_bit_d;
         if (ctl_wr) begin
            vpr_q <= w_data_q[`CTL_VPR_LSB +: 2];
         end
         if (hi_wr && prog_ok) begin
            mul_hi_q <= w_data_q[3:0];
         end
         if (lo_wr && prog_ok) begin
            mul_lo_q <= w_data_q[7:0];
         end
         if (rng_wr && prog_ok) begin
            range_q <= w_data_q[7:0];
         end
      end
   end

   // ----------------------------------------
   // Derived outputs
   // ----------------------------------------
   wire [MUL_W-1:0] mul_raw = {mul_hi_q, mul_lo_q};
   wire pll_en_d = pll_on_bit_q & ~l_zero & osc_enable_from_sysint_i;

   always_ff @(posedge core_clk_i) begin
      if (srst_i) begin
         pll_en_q  <= 1'b0;
         mul_eff_q <= '0;
      end else if (ce_i) begin
         pll_en_q  <= pll_en_d;
         mul_eff_q <= (mul_raw == '0) ? MUL_W'(1) : mul_raw;
      end
   end

   assign pll_enable_o           = pll_en_q;
   assign osc_enable_o           = osc_enable_from_sysint_i;
   assign multiplier_o           = mul_eff_q;
   assign vco_range_o            = range_q;
   assign vco_power_range_bits_o = vpr_q;

   // ----------------------------------------
   // Source selection
   // ----------------------------------------
   // The VCO is only requested while the loop is actually enabled; otherwise crystal wins.
   wire sel_vco = base_clock_select_bit_q & pll_en_q;
   logic sw_busy, sw_act;

   clk_source_switch #(
      .SETTLE           (SETTLE)
   ) u_switch (
      .core_clk_i       (core_clk_i),
      .srst_i           (srst_i),
      .ce_i             (ce_i),
      .crystal_clock_i  (crystal_clock_i),
      .vco_clock_i      (vco_clock_i),
      .sel_vco_i        (sel_vco),
      .base_clock_out_o (base_clock_out_o),
      .active_vco_o     (sw_act),
      .busy_o           (sw_busy)
   );

   assign switch_busy_o = sw_busy;
   assign active_vco_o  = sw_act;

   // ----------------------------------------
   // Read channel
   // ----------------------------------------
   logic        rvalid_q;
   logic [31:0] rdata_q;
   logic [1:0]  rresp_q;
   wire  reg_idx_t ridx = reg_index(s_axi_araddr_i);
   wire  ar_take = s_axi_arvalid_i & s_axi_arready_o;
   logic [7:0]  rd_val;

   always_comb begin
      rd_val = 8'h00;
      unique case (ridx)
         `IDX_CTL:    rd_val = {2'h0, pll_on_bit_q, base_clock_select_bit_q, 2'h0, vpr_q};
         `IDX_MUL_HI: rd_val = {4'h0, mul_hi_q};
         `IDX_MUL_LO: rd_val = mul_lo_q;
         `IDX_RANGE:  rd_val = range_q;
         `IDX_STATUS: rd_val = {5'h00, pll_en_q, sw_act, sw_busy};
         default:     rd_val = 8'h00;
      endcase
   end

   assign s_axi_arready_o = ce_i & ~rvalid_q;
   assign s_axi_rvalid_o  = rvalid_q;
   assign s_axi_rdata_o   = rdata_q;
   assign s_axi_rresp_o   = rresp_q;

   always_ff @(posedge core_clk_i) begin
      if (srst_i) begin
         rvalid_q <= 1'b0;
         rdata_q  <= 32'h0000_0000;
         rresp_q  <= `RESP_OKAY;
      end else if (ce_i) begin
         if (ar_take) begin
            rvalid_q <= 1'b1;
            rdata_q  <= {24'h00_0000, rd_val};
            rresp_q  <= mapped(ridx) ? `RESP_OKAY : `RESP_SLVERR;
         end else if (rvalid_q && s_axi_rready_i) begin
            rvalid_q <= 1'b0;
         end
      end
   end

   // ----------------------------------------
   // Checks
   // ----------------------------------------
   // Write checks compare with the held write data, because a register lands one edge after the write.
   chk_zero_mult: assert property (@(posedge core_clk_i) disable iff (srst_i)
      (ce_i && mul_raw == '0) |=> (mul_eff_q == MUL_W'(1)))
      else $error("zero multiplier not treated as one");

   chk_mult_follow: assert property (@(posedge core_clk_i) disable iff (srst_i)
      (ce_i && mul_raw != '0) |=> (mul_eff_q == $past(mul_raw)))
      else $error("multiplier output does not follow registers");

   chk_lzero_off: assert property (@(posedge core_clk_i) disable iff (srst_i)
      (l_zero && ce_i) |=> !pll_enable_o)
      else $error("pll enabled with zero range");

   chk_lzero_sel: assert property (@(posedge core_clk_i) disable iff (srst_i)
      l_zero |=> !base_clock_select_bit_q)
      else $error("vco selectable with zero range");

   chk_sel_needs_on: assert property (@(posedge core_clk_i) disable iff (srst_i)
      base_clock_select_bit_q |-> (pll_on_bit_q && !l_zero))
      else $error("vco selected while pll off");

   chk_sel_cleared: assert property (@(posedge core_clk_i) disable iff (srst_i)
      (!pll_on_bit_q || l_zero) |=> !base_clock_select_bit_q)
      else $error("select bit not held clear");

   chk_sel_write: assert property (@(posedge core_clk_i) disable iff (srst_i)
      (ctl_wr && pll_on_bit_q && !l_zero && wr_on) |=> (base_clock_select_bit_q == $past(wr_sel)))
      else $error("select bit write lost");

   chk_on_locked: assert property (@(posedge core_clk_i) disable iff (srst_i)
      (ctl_wr && base_clock_select_bit_q && !wr_on) |=> pll_on_bit_q)
      else $error("pll switched off under vco");

   chk_on_write: assert property (@(posedge core_clk_i) disable iff (srst_i)
      (ctl_wr && !base_clock_select_bit_q) |=> (pll_on_bit_q == $past(wr_on)))
      else $error("pll on write lost");

   chk_one_change: assert property (@(posedge core_clk_i) disable iff (srst_i)
      (pll_on_bit_q != $past(pll_on_bit_q)) |-> (base_clock_select_bit_q == $past(base_clock_select_bit_q)))
      else $error("pll and select changed together");

   chk_prog_ro: assert property (@(posedge core_clk_i) disable iff (srst_i)
      (pll_on_bit_q && (hi_wr || lo_wr || rng_wr)) |=> $stable(mul_raw) && $stable(range_q))
      else $error("programming changed while pll on");

   chk_hi_write: assert property (@(posedge core_clk_i) disable iff (srst_i)
      (!pll_on_bit_q && hi_wr) |=> (mul_hi_q == $past(w_data_q[3:0])))
      else $error("multiplier high write lost");

   chk_lo_write: assert property (@(posedge core_clk_i) disable iff (srst_i)
      (!pll_on_bit_q && lo_wr) |=> (mul_lo_q == $past(w_data_q[7:0])))
      else $error("multiplier low write lost");

   chk_range_write: assert property (@(posedge core_clk_i) disable iff (srst_i)
      (!pll_on_bit_q && rng_wr) |=> (range_q == $past(w_data_q[7:0])))
      else $error("range write lost while pll off");

   chk_vpr_write: assert property (@(posedge core_clk_i) disable iff (srst_i)
      ctl_wr |=> (vpr_q == $past(w_data_q[`CTL_VPR_LSB +: 2])))
      else $error("power range write lost");

   chk_osc_gate: assert property (@(posedge core_clk_i) disable iff (srst_i)
      (!osc_enable_from_sysint_i && ce_i) |=> !pll_enable_o)
      else $error("pll enabled without oscillator enable");

   chk_write_resp: assert property (@(posedge core_clk_i) disable iff (srst_i)
      wr_fire |=> (bvalid_q && !aw_full_q && !w_full_q))
      else $error("write not answered");
endmodule // pll_base_clock_select
`default_nettype wire

//--- test/sysint_model.sv
`timescale 1ns/100ps
`default_nettype none
// ----------------------------------------
// Integration-unit side of the clock block.
// ----------------------------------------
module sysint_model (
   input  wire logic osc_req_i,
   input  wire logic osc_enable_i,
   input  wire logic pll_enable_i,
   input  wire logic base_clock_i,
   output logic      osc_enable_o,
   output logic      crystal_clock_o,
   output logic      vco_clock_o,
   output logic      bus_clock_o,
   output var int    base_period_o
);
   realtime last_t;
   assign osc_enable_o = osc_req_i;
   // Odd half periods keep both sources off the core clock edges, so sync races never decide a result.
   initial begin
      crystal_clock_o = 1'b0;
      forever begin
         #201.7;
         crystal_clock_o = osc_enable_i ? ~crystal_clock_o : 1'b0;
      end
   end
   // A disabled loop stops low instead of running on.
   initial begin
      vco_clock_o = 1'b0;
      forever begin
         #156.1;
         vco_clock_o = (osc_enable_i && pll_enable_i) ? ~vco_clock_o : 1'b0;
      end
   end
   initial begin
      bus_clock_o   = 1'b0;
      last_t        = 0.0;
      base_period_o = 0;
   end
   always @(posedge base_clock_i) begin
      bus_clock_o   <= ~bus_clock_o;
      base_period_o <= int'($realtime - last_t);
      last_t        <= $realtime;
   end
endmodule // sysint_model
`default_nettype wire

//--- test/pll_base_clock_select_tb_top.sv
`timescale 1ns/100ps
`default_nettype none
`include "pll_clk_defs.svh"
module pll_base_clock_select_tb_top;
   localparam logic [7:0] A_CTL = {`IDX_CTL, 2'b00};
   localparam logic [7:0] A_HI  = {`IDX_MUL_HI, 2'b00};
   localparam logic [7:0] A_LO  = {`IDX_MUL_LO, 2'b00};
   localparam logic [7:0] A_RNG = {`IDX_RANGE, 2'b00};
   localparam logic [7:0] A_STS = {`IDX_STATUS, 2'b00};
   // Reference near 2.48 MHz, VCO near 3.2 MHz: N rounds to 1, E is 0, L rounds to 45.
   localparam logic [7:0] N_VAL = 8'h01;
   localparam logic [7:0] L_VAL = 8'h2d;
   logic        core_clk_i, srst_i, ce_i, osc_req, osc_en, xclk, vclk, bus_clk, base_clk;
   logic        awvalid, wvalid, bready, arvalid, rready, awready, wready, bvalid, arready, rvalid;
   logic        osc_en_o, pll_en, busy, act_vco, base_prev, busy_prev, frz_base;
   logic [7:0]  awaddr, araddr, vrange;
   logic [31:0] wdata, rdata, lfsr_q;
   logic [3:0]  wstrb;
   logic [1:0]  bresp, rresp, vco_power_range_bits;
   logic [11:0] mult;
   int          err_total, total_checks, base_period, busy_len;
   logic [33:0] rd_q[$];
   logic [1:0]  wr_q[$];
   // ----------------------------------------
   // Design, far side and clock.
   // ----------------------------------------
   pll_base_clock_select dut_u (.core_clk_i(core_clk_i), .srst_i(srst_i), .ce_i(ce_i),
      .osc_enable_from_sysint_i(osc_en), .crystal_clock_i(xclk), .vco_clock_i(vclk),
      .s_axi_awaddr_i(awaddr), .s_axi_awvalid_i(awvalid), .s_axi_awready_o(awready),
      .s_axi_wdata_i(wdata), .s_axi_wstrb_i(wstrb), .s_axi_wvalid_i(wvalid), .s_axi_wready_o(wready),
      .s_axi_bresp_o(bresp), .s_axi_bvalid_o(bvalid), .s_axi_bready_i(bready),
      .s_axi_araddr_i(araddr), .s_axi_arvalid_i(arvalid), .s_axi_arready_o(arready),
      .s_axi_rdata_o(rdata), .s_axi_rresp_o(rresp), .s_axi_rvalid_o(rvalid), .s_axi_rready_i(rready),
      .base_clock_out_o(base_clk), .osc_enable_o(osc_en_o), .pll_enable_o(pll_en), .multiplier_o(mult),
      .vco_range_o(vrange), .vco_power_range_bits_o(vco_power_range_bits), .switch_busy_o(busy), .active_vco_o(act_vco));
   sysint_model far_u (.osc_req_i(osc_req), .osc_enable_i(osc_en_o), .pll_enable_i(pll_en),
      .base_clock_i(base_clk), .osc_enable_o(osc_en), .crystal_clock_o(xclk), .vco_clock_o(vclk),
      .bus_clock_o(bus_clk), .base_period_o(base_period));
   initial begin
      core_clk_i = 1'b0;
      forever #25 core_clk_i = ~core_clk_i;
   end
   // ----------------------------------------
   // Tasks.
   // ----------------------------------------
   function automatic logic [31:0] lfsr_step(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction
   task automatic check(input logic [33:0] seen, input logic [33:0] exp);
      total_checks++;
      if (seen !== exp) begin
         err_total++;
         $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   // Upper data bits and upper strobes are random; the block keeps only byte 0 under strobe 0.
   task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic [1:0] er);
      logic aw_hit, w_hit, b_hit;
      int   n;
      wr_q.push_back(er);
      lfsr_q = lfsr_step(lfsr_q);
      @(posedge core_clk_i);
      awaddr  <= a;
      wdata   <= {lfsr_q[23:0], d};
      wstrb   <= {lfsr_q[2:0], 1'b1};
      awvalid <= 1'b1;
      wvalid  <= 1'b1;
      bready  <= 1'b1;
      b_hit = 1'b0;
      for (n = 0; n < 400 && !b_hit; n++) begin
         @(negedge core_clk_i);
         aw_hit = awvalid && awready;
         w_hit  = wvalid && wready;
         b_hit  = bvalid;
         @(posedge core_clk_i);
         if (aw_hit) awvalid <= 1'b0;
         if (w_hit) wvalid <= 1'b0;
      end
      bready <= 1'b0;
   endtask
   task automatic rd(input logic [7:0] a, input logic [7:0] d, input logic [1:0] er);
      logic ar_hit, r_hit;
      int   n;
      rd_q.push_back({er, 24'h0, d});
      @(posedge core_clk_i);
      araddr  <= a;
      arvalid <= 1'b1;
      rready  <= 1'b1;
      r_hit = 1'b0;
      for (n = 0; n < 400 && !r_hit; n++) begin
         @(negedge core_clk_i);
         ar_hit = arvalid && arready;
         r_hit  = rvalid;
         @(posedge core_clk_i);
         if (ar_hit) arvalid <= 1'b0;
      end
      rready <= 1'b0;
   endtask
   // Forty cycles after the switch leave room for two base clock periods to be measured.
   task automatic settle();
      int n;
      repeat (8) @(posedge core_clk_i);
      for (n = 0; n < 300 && busy !== 1'b0; n++) @(posedge core_clk_i);
      repeat (40) @(negedge core_clk_i);
   endtask
   task automatic close_out();
      $display("checks=%0d errors=%0d", total_checks, err_total);
      if (err_total == 0 && total_checks > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask
   // ----------------------------------------
   // Watchers.
   // ----------------------------------------
   always @(negedge core_clk_i) begin
      if (rvalid && rready) check({rresp, rdata}, rd_q.size() ? rd_q.pop_front() : 34'h3);
      if (bvalid && bready) check(34'(bresp), 34'(wr_q.size() ? wr_q.pop_front() : 2'h1));
      if (busy_prev === 1'b1 && busy === 1'b1) check(34'(base_clk), 34'(base_prev));
      busy_len = (busy === 1'b1) ? busy_len + 1 : 0;
      if (busy_len == 200) check(34'h1, 34'h0);
      busy_prev = busy;
      base_prev = base_clk;
   end
   initial begin
      #1_000_000;
      err_total++;
      close_out();
   end
   // ----------------------------------------
   // Main sequence.
   // ----------------------------------------
   initial begin
      {srst_i, ce_i, osc_req, lfsr_q} = {3'b111, 32'hacf3};
      {awvalid, wvalid, bready, arvalid, rready, awaddr, araddr, wdata, wstrb} = '0;
      {err_total, total_checks, busy_len, busy_prev, base_prev} = '0;
      repeat (3) @(posedge core_clk_i);
      srst_i <= 1'b0;
      rd(A_CTL, `CTL_RST, `RESP_OKAY);
      rd(A_HI, 8'(`MUL_HI_RST), `RESP_OKAY);
      wr(A_LO, 8'h00, `RESP_OKAY);
      rd(A_LO, `MUL_LO_RST, `RESP_OKAY);
      rd(A_RNG, `RANGE_RST, `RESP_OKAY);
      @(negedge core_clk_i);
      check(34'(pll_en), 34'h1);
      check(34'(mult), 34'h040);
      wr(A_CTL, 8'h00, `RESP_OKAY);
      wr(A_CTL, 8'h10, `RESP_OKAY);
      rd(A_CTL, 8'h00, `RESP_OKAY);
      wr(A_CTL, 8'h31, `RESP_OKAY);
      rd(A_CTL, 8'h21, `RESP_OKAY);
      check(34'(vco_power_range_bits), 34'h1);
      wr(A_CTL, 8'h01, `RESP_OKAY);
      wr(A_HI, 8'h00, `RESP_OKAY);
      wr(A_LO, 8'h00, `RESP_OKAY);
      @(negedge core_clk_i);
      check(34'(mult), 34'h001);
      wr(A_RNG, 8'h00, `RESP_OKAY);
      wr(A_CTL, 8'h20, `RESP_OKAY);
      wr(A_CTL, 8'h30, `RESP_OKAY);
      rd(A_CTL, 8'h20, `RESP_OKAY);
      check(34'(pll_en), 34'h0);
      check(34'(act_vco), 34'h0);
      wr(A_CTL, 8'h00, `RESP_OKAY);
      wr(A_LO, N_VAL, `RESP_OKAY);
      wr(A_RNG, L_VAL, `RESP_OKAY);
      rd(A_RNG, L_VAL, `RESP_OKAY);
      wr(A_CTL, 8'h20, `RESP_OKAY);
      settle();
      check(34'(mult), 34'(N_VAL));
      check(34'(vrange), 34'(L_VAL));
      check(34'(base_period > 700 && base_period < 920), 34'h1);
      wr(A_CTL, 8'h30, `RESP_OKAY);
      settle();
      check(34'(act_vco), 34'h1);
      check(34'(base_period > 560 && base_period < 690), 34'h1);
      rd(A_STS, 8'h06, `RESP_OKAY);
      wr(A_CTL, 8'h10, `RESP_OKAY);
      rd(A_CTL, 8'h30, `RESP_OKAY);
      wr(A_CTL, 8'h20, `RESP_OKAY);
      settle();
      check(34'(act_vco), 34'h0);
      check(34'(base_period > 700 && base_period < 920), 34'h1);
      rd(8'h00, 8'h00, `RESP_SLVERR);
      wr(8'h04, 8'h5a, `RESP_SLVERR);
      @(posedge core_clk_i);
      ce_i <= 1'b0;
      @(negedge core_clk_i);
      frz_base = base_clk;
      repeat (30) begin
         @(negedge core_clk_i);
         check(34'(base_clk), 34'(frz_base));
      end
      check(34'({awready, wready, arready}), 34'h0);
      @(posedge core_clk_i);
      ce_i <= 1'b1;
      @(posedge core_clk_i);
      osc_req <= 1'b0;
      repeat (3) @(negedge core_clk_i);
      check(34'(osc_en_o), 34'h0);
      check(34'(pll_en), 34'h0);
      @(posedge core_clk_i);
      osc_req <= 1'b1;
      close_out();
   end
endmodule // pll_base_clock_select_tb_top
`default_nettype wire
